// ---- core/gst_pkg.sv ----
// shared constants of the gated sixteen bit timer
package gst_pkg;

  localparam logic [3:0]  ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  ADDR_CNT_L   = 4'h1;
  localparam logic [3:0]  ADDR_CNT_H   = 4'h2;
  localparam logic [3:0]  ADDR_FLAG    = 4'h3;
  localparam logic [3:0]  ADDR_IE      = 4'h4;
  localparam logic [3:0]  ADDR_IRQCTL  = 4'h5;
  localparam logic [3:0]  ADDR_COMPCTL = 4'h6;
  localparam logic [3:0]  ADDR_PORT    = 4'h7;
  localparam logic [3:0]  ADDR_CC_L    = 4'h8;
  localparam logic [3:0]  ADDR_CC_H    = 4'h9;
  localparam logic [3:0]  ADDR_CC_MODE = 4'hA;

  localparam int          CTL_ON       = 0;
  localparam int          CTL_CS       = 1;
  localparam int          CTL_SYNC     = 2;
  localparam int          CTL_OSC      = 3;
  localparam int          CTL_PS_LO    = 4;
  localparam int          CTL_PS_HI    = 5;
  localparam int          CTL_GE       = 6;
  localparam int          CTL_GINV     = 7;
  localparam int          FLAG_BIT     = 0;
  localparam int          IE_BIT       = 0;
  localparam int          PERIPHERAL_IRQ_ENABLE_BIT     = 6;
  localparam int          GIE_BIT      = 7;
  localparam int          GSEL_BIT     = 1;
  localparam int          MODE_CAP     = 0;
  localparam int          MODE_CMP     = 1;
  localparam int          MODE_SPEC    = 2;

  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CC_RST       = 16'h0000;
  localparam logic [2:0]  MODE_RST     = 3'h0;
  localparam logic [1:0]  DIR_FORCED   = 2'h3;
  localparam logic [1:0]  DATA_FORCED  = 2'h0;

endpackage : gst_pkg

// ---- core/gst_cc_if.sv ----
// link between the timer and its capture/compare unit
interface gst_cc_if;
  logic [15:0] count;
  logic        wr;
  logic [3:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        trigger;
  logic        match;

  modport timer (output count, output wr, output addr, output wdata,
                 input rdata, input trigger, input match);
  modport unit  (input count, input wr, input addr, input wdata,
                 output rdata, output trigger, output match);
endinterface : gst_cc_if

// ---- core/gst_capcomp.sv ----
// capture/compare unit using the timer count as its time base
module gst_capcomp (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic capture_pin,
  gst_cc_if.unit    cc
);

  typedef struct packed {
    logic [15:0] cc;
    logic [2:0]  mode;
    logic        s1;
    logic        s2;
    logic        s3;
    logic        eq_prev;
    logic        match;
  } gst_cc_state_type;

  gst_cc_state_type state_reg;
  gst_cc_state_type state_next;
  logic             cap_edge;
  logic             eq;

  assign cap_edge = state_reg.s2 & ~state_reg.s3;
  assign eq = state_reg.mode[gst_pkg::MODE_CMP] & (cc.count == state_reg.cc);
  assign cc.match = state_reg.match;
  assign cc.trigger = state_reg.match & state_reg.mode[gst_pkg::MODE_SPEC];

  always_comb begin
    state_next = state_reg;
    state_next.s1 = capture_pin;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    state_next.eq_prev = eq;
    state_next.match = eq & ~state_reg.eq_prev;
    if (cc.wr) begin
      case (cc.addr)
        gst_pkg::ADDR_CC_L: state_next.cc[7:0] = cc.wdata;
        gst_pkg::ADDR_CC_H: state_next.cc[15:8] = cc.wdata;
        gst_pkg::ADDR_CC_MODE: state_next.mode = cc.wdata[2:0];
        default: ;
      endcase
    end
    if (state_reg.mode[gst_pkg::MODE_CAP] && cap_edge) begin
      state_next.cc = cc.count;
    end
  end

  always_comb begin
    case (cc.addr)
      gst_pkg::ADDR_CC_L: cc.rdata = state_reg.cc[7:0];
      gst_pkg::ADDR_CC_H: cc.rdata = state_reg.cc[15:8];
      gst_pkg::ADDR_CC_MODE: cc.rdata = {5'h00, state_reg.mode};
      default: cc.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.cc <= gst_pkg::CC_RST;
      state_reg.mode <= gst_pkg::MODE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  a_capture_copy: assert property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg.mode[gst_pkg::MODE_CAP] && cap_edge |=> state_reg.cc == $past(cc.count))
    else $error("capture did not copy the count");

  a_compare_match: assert property (@(posedge sys_clk) disable iff (!rst_n)
    eq && !state_reg.eq_prev |=> cc.match ##1 !cc.match)
    else $error("compare match pulse wrong");

  c_capture: cover property (@(posedge sys_clk) disable iff (!rst_n)
    state_reg.mode[gst_pkg::MODE_CAP] && cap_edge);

endmodule : gst_capcomp

// ---- core/gst_timer.sv ----
// gated sixteen bit timer with prescaler, gate, overflow flag and trigger
//
// Contract
// - oscillator runs only while osc_enable set, also during sleep
// - oscillator enabled: port direction bits read one, data bits zero
// - unsynchronized external mode counts in sleep and can wake
// - switching sync mode may lose or add one increment
// - counter bytes read valid while counting unsynchronized clock
// - gate source selects gate pin or comparator two output
// - gating acts only when gate_enable set
// - gate_invert inverts the selected gate signal
// - counter wraps FFFF to 0000 and sets overflow_flag
// - interrupt needs flag, irq enable, peripheral and global enables
// - counting in sleep only in unsynchronized external mode
// - overflow in sleep with enables set wakes the device
// - capture copies count into capture/compare pair
// - compare match of pair and count raises an event
// - special trigger clears count without setting overflow_flag
// - counter write beats a coincident special trigger clear
// - clock_source_select: zero internal clock, one external input
// - prescaler divides by 1, 2, 4, 8, cleared by count writes
// - software writes to count bytes update the counter directly
// - counter mode increments on external clock rising edges
module gst_timer (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] bus_addr,
  input  wire logic [7:0] bus_wdata,
  input  wire logic       bus_wr,
  input  wire logic       bus_rd,
  output logic [7:0]      bus_rdata,
  input  wire logic       ext_clock_pin,
  input  wire logic       crystal_in_pin,
  input  wire logic       gate_pin,
  input  wire logic       comparator_two_output,
  input  wire logic       capture_pin,
  input  wire logic       sleep,
  input  wire logic       osc_in_dir_bit,
  input  wire logic       osc_out_dir_bit,
  input  wire logic       osc_in_port_bit,
  input  wire logic       osc_out_port_bit,
  output logic            osc_run,
  output logic            irq_request,
  output logic            wake_request,
  output logic            compare_event
);

  typedef struct packed {
    logic [7:0]  ctl;
    logic [15:0] cnt;
    logic [2:0]  pre;
    logic        flag;
    logic        ie;
    logic        peripheral_irq_enable;
    logic        global_irq_enable;
    logic        gsel;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic        s3;
    logic        s4;
    logic [7:0]  rdata;
    logic        irq;
    logic        wake;
    logic        osc;
    logic        cmp;
  } gst_state_type;

  gst_state_type state_reg;
  gst_state_type state_next;
  gst_cc_if      cc_bus ();

  logic       ext_src;
  logic       edge_async;
  logic       edge_sync;
  logic       src_tick;
  logic [1:0] ps;
  logic [2:0] pre_mask;
  logic       pre_hit;
  logic       gate_raw;
  logic       gate_open;
  logic       run;
  logic       inc;
  logic       wr_lo;
  logic       wr_hi;
  logic       cnt_wr;
  logic       quiet;
  logic       ovf;
  logic [1:0] dir_view;
  logic [1:0] data_view;

  assign cc_bus.count = state_reg.cnt;
  assign cc_bus.wr = bus_wr;
  assign cc_bus.addr = bus_addr;
  assign cc_bus.wdata = bus_wdata;

  gst_capcomp gst_capcomp_inst (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .capture_pin (capture_pin),
    .cc          (cc_bus)
  );

  // external source: crystal while the oscillator runs, else the clock pin
  assign ext_src = state_reg.ctl[gst_pkg::CTL_OSC] ? state_reg.s2[1] : state_reg.s2[0];
  // unsync path sees the edge one stage before the sync path
  assign edge_async = ext_src & ~state_reg.s3;
  assign edge_sync = state_reg.s3 & ~state_reg.s4;
  assign src_tick = state_reg.ctl[gst_pkg::CTL_CS] ?
                    (state_reg.ctl[gst_pkg::CTL_SYNC] ? edge_async
                                                      : edge_sync & ~sleep)
                    : ~sleep;
  assign ps = state_reg.ctl[gst_pkg::CTL_PS_HI:gst_pkg::CTL_PS_LO];
  assign pre_mask = 3'((4'h1 << ps) - 4'h1);
  // masked compare: a prescale change never leaves the counter stuck above its top
  assign pre_hit = (state_reg.pre & pre_mask) == pre_mask;
  assign gate_raw = state_reg.gsel ? state_reg.s2[3] : state_reg.s2[2];
  assign gate_open = ~state_reg.ctl[gst_pkg::CTL_GE] |
                     (gate_raw ^ state_reg.ctl[gst_pkg::CTL_GINV]);
  assign run = state_reg.ctl[gst_pkg::CTL_ON] & gate_open;
  assign inc = run & src_tick & pre_hit;
  assign wr_lo = bus_wr & (bus_addr == gst_pkg::ADDR_CNT_L);
  assign wr_hi = bus_wr & (bus_addr == gst_pkg::ADDR_CNT_H);
  assign cnt_wr = wr_lo | wr_hi;
  assign quiet = ~cnt_wr & ~cc_bus.trigger;
  assign ovf = inc & quiet & (state_reg.cnt == gst_pkg::COUNT_MAX);
  assign dir_view = state_reg.ctl[gst_pkg::CTL_OSC] ? gst_pkg::DIR_FORCED
                                                    : {osc_out_dir_bit, osc_in_dir_bit};
  assign data_view = state_reg.ctl[gst_pkg::CTL_OSC] ? gst_pkg::DATA_FORCED
                                                     : {osc_out_port_bit, osc_in_port_bit};

  always_comb begin
    state_next = state_reg;
    state_next.s1 = {comparator_two_output, gate_pin, crystal_in_pin, ext_clock_pin};
    state_next.s2 = state_reg.s1;
    state_next.s3 = ext_src;
    state_next.s4 = state_reg.s3;
    state_next.irq = state_reg.flag & state_reg.ie & state_reg.peripheral_irq_enable & state_reg.global_irq_enable;
    state_next.wake = sleep & state_reg.ctl[gst_pkg::CTL_ON] & state_reg.flag &
                      state_reg.ie & state_reg.peripheral_irq_enable;
    state_next.osc = state_reg.ctl[gst_pkg::CTL_OSC];
    state_next.cmp = cc_bus.match;
    if (bus_wr) begin
      case (bus_addr)
        gst_pkg::ADDR_CTRL: state_next.ctl = bus_wdata;
        gst_pkg::ADDR_FLAG: state_next.flag = bus_wdata[gst_pkg::FLAG_BIT];
        gst_pkg::ADDR_IE: state_next.ie = bus_wdata[gst_pkg::IE_BIT];
        gst_pkg::ADDR_IRQCTL: begin
          state_next.peripheral_irq_enable = bus_wdata[gst_pkg::PERIPHERAL_IRQ_ENABLE_BIT];
          state_next.global_irq_enable = bus_wdata[gst_pkg::GIE_BIT];
        end
        gst_pkg::ADDR_COMPCTL: state_next.gsel = bus_wdata[gst_pkg::GSEL_BIT];
        default: ;
      endcase
    end
    // write first, then trigger clear, then counting
    if (cnt_wr) begin
      if (wr_lo) begin
        state_next.cnt[7:0] = bus_wdata;
      end
      if (wr_hi) begin
        state_next.cnt[15:8] = bus_wdata;
      end
      state_next.pre = 3'h0;
    end else if (cc_bus.trigger) begin
      state_next.cnt = gst_pkg::COUNT_RST;
    end else if (run && src_tick) begin
      state_next.pre = pre_hit ? 3'h0 : state_reg.pre + 3'h1;
      if (pre_hit) begin
        state_next.cnt = state_reg.cnt + 16'h0001;
      end
    end
    // hardware set beats a software clear
    if (ovf) begin
      state_next.flag = 1'b1;
    end
    state_next.rdata = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        gst_pkg::ADDR_CTRL: state_next.rdata = state_reg.ctl;
        gst_pkg::ADDR_CNT_L: state_next.rdata = state_reg.cnt[7:0];
        gst_pkg::ADDR_CNT_H: state_next.rdata = state_reg.cnt[15:8];
        gst_pkg::ADDR_FLAG: state_next.rdata = {7'h00, state_reg.flag};
        gst_pkg::ADDR_IE: state_next.rdata = {7'h00, state_reg.ie};
        gst_pkg::ADDR_IRQCTL: state_next.rdata = {state_reg.global_irq_enable, state_reg.peripheral_irq_enable, 6'h00};
        gst_pkg::ADDR_COMPCTL: state_next.rdata = {6'h00, state_reg.gsel, 1'b0};
        gst_pkg::ADDR_PORT: state_next.rdata = {4'h0, dir_view, data_view};
        gst_pkg::ADDR_CC_L: state_next.rdata = cc_bus.rdata;
        gst_pkg::ADDR_CC_H: state_next.rdata = cc_bus.rdata;
        gst_pkg::ADDR_CC_MODE: state_next.rdata = cc_bus.rdata;
        default: state_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.ctl <= gst_pkg::CTRL_RST;
      state_reg.cnt <= gst_pkg::COUNT_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata = state_reg.rdata;
  assign osc_run = state_reg.osc;
  assign irq_request = state_reg.irq;
  assign wake_request = state_reg.wake;
  assign compare_event = state_reg.cmp;

  default clocking gst_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_wrap_sets_flag: assert property (
    ovf |=> state_reg.flag && state_reg.cnt == gst_pkg::COUNT_RST)
    else $error("wrap did not clear count and set flag");

  a_flag_set_wins: assert property (
    ovf && bus_wr && bus_addr == gst_pkg::ADDR_FLAG |=> state_reg.flag)
    else $error("flag clear beat an overflow");

  a_trigger_no_flag: assert property (
    cc_bus.trigger && !cnt_wr && !state_reg.flag &&
    !(bus_wr && bus_addr == gst_pkg::ADDR_FLAG)
    |=> state_reg.cnt == gst_pkg::COUNT_RST && !state_reg.flag)
    else $error("trigger clear wrong");

  a_write_beats_trig: assert property (
    wr_hi && cc_bus.trigger |=> state_reg.cnt[15:8] == $past(bus_wdata))
    else $error("trigger beat a counter write");

  a_low_write_direct: assert property (
    wr_lo |=> state_reg.cnt[7:0] == $past(bus_wdata) && state_reg.pre == 3'h0)
    else $error("low byte write not applied");

  a_off_holds: assert property (
    !state_reg.ctl[gst_pkg::CTL_ON] && quiet |=> $stable(state_reg.cnt))
    else $error("counter moved while off");

  a_gate_holds: assert property (
    state_reg.ctl[gst_pkg::CTL_GE] &&
    !(gate_raw ^ state_reg.ctl[gst_pkg::CTL_GINV]) && quiet
    |=> $stable(state_reg.cnt))
    else $error("counter moved while gated");

  a_sleep_stops: assert property (
    sleep && !(state_reg.ctl[gst_pkg::CTL_CS] && state_reg.ctl[gst_pkg::CTL_SYNC]) && quiet
    |=> $stable(state_reg.cnt))
    else $error("counter moved in sleep");

  a_async_sleep_count: assert property (
    sleep && inc && quiet && state_reg.ctl[gst_pkg::CTL_SYNC]
    |=> state_reg.cnt == $past(state_reg.cnt) + 16'h0001)
    else $error("async counter stalled in sleep");

  a_internal_tick: assert property (
    state_reg.ctl[gst_pkg::CTL_ON] && !state_reg.ctl[gst_pkg::CTL_GE] &&
    !state_reg.ctl[gst_pkg::CTL_CS] && ps == 2'h0 && !sleep && quiet
    |=> state_reg.cnt == $past(state_reg.cnt) + 16'h0001)
    else $error("internal clock did not count");

  a_prescale_eight: assert property (
    run && src_tick && quiet && ps == 2'h3 && state_reg.pre == 3'h7
    |=> state_reg.pre == 3'h0)
    else $error("prescaler did not wrap at eight");

  a_irq_enables: assert property (
    (state_reg.flag && state_reg.ie && state_reg.peripheral_irq_enable && state_reg.global_irq_enable) [*2]
    |-> irq_request)
    else $error("interrupt not raised");

  a_irq_masked: assert property (
    !state_reg.global_irq_enable |=> !irq_request)
    else $error("interrupt raised while masked");

  a_wake_sleep: assert property (
    (sleep && state_reg.ctl[gst_pkg::CTL_ON] && state_reg.flag &&
     state_reg.ie && state_reg.peripheral_irq_enable) [*2] |-> wake_request)
    else $error("no wake on overflow in sleep");

  a_port_forced: assert property (
    bus_rd && bus_addr == gst_pkg::ADDR_PORT && state_reg.ctl[gst_pkg::CTL_OSC]
    |=> bus_rdata[3:0] == 4'hC)
    else $error("oscillator port bits not forced");

  a_osc_follows: assert property (
    state_reg.ctl[gst_pkg::CTL_OSC] [*2] |-> osc_run)
    else $error("oscillator not running");

  c_wrap: cover property (ovf);
  c_trigger: cover property (cc_bus.trigger && quiet);
  c_wake: cover property (sleep && wake_request);
  c_gated: cover property (state_reg.ctl[gst_pkg::CTL_GE] && !gate_open && src_tick);

endmodule : gst_timer

// ---- dv/gst_far_side.sv ----
// far side model: external count clock, crystal, gate pin, comparator output
module gst_far_side (
  input  wire logic sys_clk,
  output logic      ext_clock_pin,
  output logic      crystal_in_pin,
  output logic      gate_pin,
  output logic      comparator_two_output
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ext_clock_pin         = 1'h0;
    crystal_in_pin        = 1'h0;
    gate_pin              = 1'h0;
    comparator_two_output = 1'h0;
  end

  // bursts of rising edges, clocks stand low between bursts
  task automatic pulses(input logic xtal, input int n, input int half);
    repeat (n) begin
      @(posedge sys_clk);
      crystal_in_pin <= xtal;
      ext_clock_pin  <= !xtal;
      repeat (half) @(posedge sys_clk);
      crystal_in_pin <= 1'h0;
      ext_clock_pin  <= 1'h0;
      repeat (half - 1) @(posedge sys_clk);
    end
  endtask : pulses

  // gate pin and comparator output move together on a sys_clk rising edge
  task automatic set_gate(input logic pin, input logic cmp);
    @(posedge sys_clk);
    gate_pin              <= pin;
    comparator_two_output <= cmp;
  endtask : set_gate
endmodule : gst_far_side

// ---- dv/gst_timer_tb.sv ----
// self-checking bench of the gated sixteen bit timer
module gst_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic       sys_clk;
  logic       rst_n;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata;
  logic       bus_wr;
  logic       bus_rd;
  logic [7:0] bus_rdata;
  logic       ext_clock_pin;
  logic       crystal_in_pin;
  logic       gate_pin;
  logic       comparator_two_output;
  logic       capture_pin;
  logic       sleep;
  logic [3:0] osc_bits;
  logic       osc_run;
  logic       irq_request;
  logic       wake_request;
  logic       compare_event;
  int         num_errors;
  int         samples_checked;
  int         cmp_pulses;

  gst_timer gst_timer_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin),
    .gate_pin(gate_pin), .comparator_two_output(comparator_two_output),
    .capture_pin(capture_pin), .sleep(sleep),
    .osc_in_dir_bit(osc_bits[2]), .osc_out_dir_bit(osc_bits[3]),
    .osc_in_port_bit(osc_bits[0]), .osc_out_port_bit(osc_bits[1]),
    .osc_run(osc_run), .irq_request(irq_request), .wake_request(wake_request),
    .compare_event(compare_event)
  );

  gst_far_side gst_far_side_inst (
    .sys_clk(sys_clk), .ext_clock_pin(ext_clock_pin), .crystal_in_pin(crystal_in_pin),
    .gate_pin(gate_pin), .comparator_two_output(comparator_two_output)
  );

  initial sys_clk = 1'h0;
  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (compare_event === 1'h1) cmp_pulses++;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'h1;
    @(posedge sys_clk);
    bus_wr    <= 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd   <= 1'h1;
    @(posedge sys_clk);
    bus_rd   <= 1'h0;
    #1;
    d = bus_rdata;
  endtask : rd

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic expect_reg(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] got;
    rd(a, got);
    chk_byte(got, exp);
  endtask : expect_reg

  task automatic expect_count(input logic [15:0] exp);
    expect_reg(gst_pkg::ADDR_CNT_L, exp[7:0]);
    expect_reg(gst_pkg::ADDR_CNT_H, exp[15:8]);
  endtask : expect_count

  // timer stopped before loading
  task automatic load_count(input logic [15:0] v);
    wr(gst_pkg::ADDR_CNT_L, v[7:0]);
    wr(gst_pkg::ADDR_CNT_H, v[15:8]);
  endtask : load_count

  // exactly n count clock ticks with timer_on set
  task automatic run(input logic [7:0] ctrl, input int n);
    wr(gst_pkg::ADDR_CTRL, ctrl);
    repeat (n - 2) @(posedge sys_clk);
    wr(gst_pkg::ADDR_CTRL, ctrl & 8'hFE);
  endtask : run

  task automatic test_regs;
    expect_reg(gst_pkg::ADDR_CTRL, gst_pkg::CTRL_RST);
    expect_count(gst_pkg::COUNT_RST);
    expect_reg(gst_pkg::ADDR_FLAG, 8'h00);
    wr(4'hB, 8'h5A);
    expect_reg(4'hB, 8'h00);
    wr(gst_pkg::ADDR_CTRL, 8'hF4);
    expect_reg(gst_pkg::ADDR_CTRL, 8'hF4);
    wr(gst_pkg::ADDR_CTRL, 8'h00);
    expect_reg(gst_pkg::ADDR_PORT, 8'h0A);
    wr(gst_pkg::ADDR_CTRL, 8'h08);
    repeat (2) @(posedge sys_clk);
    @(posedge sys_clk) sleep <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk_bit(osc_run, 1'h1);
    expect_reg(gst_pkg::ADDR_PORT, 8'h0C);
    @(posedge sys_clk) sleep <= 1'h0;
    wr(gst_pkg::ADDR_CTRL, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk_bit(osc_run, 1'h0);
    $display("test regs done");
  endtask : test_regs

  task automatic test_prescale;
    for (int i = 0; i < 4; i++) begin
      load_count(16'h0000);
      run({2'h0, 2'(i), 4'h1}, 16);
      expect_count(16'h0010 >> i);
    end
    load_count(16'h0000);
    @(posedge sys_clk) sleep <= 1'h1;
    run(8'h01, 16);
    @(posedge sys_clk) sleep <= 1'h0;
    expect_count(16'h0000);
    $display("test prescale done");
  endtask : test_prescale

  task automatic test_overflow;
    load_count(16'hFFFE);
    run(8'h01, 3);
    expect_count(16'h0001);
    expect_reg(gst_pkg::ADDR_FLAG, 8'h01);
    wr(gst_pkg::ADDR_IE, 8'h01);
    wr(gst_pkg::ADDR_IRQCTL, 8'h40);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq_request, 1'h0);
    wr(gst_pkg::ADDR_IRQCTL, 8'hC0);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq_request, 1'h1);
    @(posedge sys_clk) sleep <= 1'h1;
    wr(gst_pkg::ADDR_CTRL, 8'h01);
    repeat (2) @(posedge sys_clk);
    chk_bit(wake_request, 1'h1);
    wr(gst_pkg::ADDR_CTRL, 8'h00);
    @(posedge sys_clk) sleep <= 1'h0;
    wr(gst_pkg::ADDR_FLAG, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq_request, 1'h0);
    wr(gst_pkg::ADDR_IE, 8'h00);
    wr(gst_pkg::ADDR_IRQCTL, 8'h00);
    $display("test overflow done");
  endtask : test_overflow

  task automatic test_gate;
    logic sel;
    logic inv;
    logic lvl;
    logic g;
    for (int i = 0; i < 8; i++) begin
      {sel, inv, lvl} = 3'(i);
      g = sel ? !lvl : lvl;
      wr(gst_pkg::ADDR_COMPCTL, {6'h00, sel, 1'h0});
      gst_far_side_inst.set_gate(lvl, !lvl);
      repeat (4) @(posedge sys_clk);
      load_count(16'h0000);
      run({inv, 7'h41}, 16);
      expect_count((g ^ inv) ? 16'h0010 : 16'h0000);
    end
    load_count(16'h0000);
    run(8'h01, 16);
    expect_count(16'h0010);
    $display("test gate done");
  endtask : test_gate

  task automatic test_external;
    load_count(16'h0000);
    wr(gst_pkg::ADDR_CTRL, 8'h03);
    gst_far_side_inst.pulses(1'h0, 5, 3);
    repeat (8) @(posedge sys_clk);
    wr(gst_pkg::ADDR_CTRL, 8'h02);
    expect_count(16'h0005);
    load_count(16'hFFFE);
    wr(gst_pkg::ADDR_CTRL, 8'h07);
    wr(gst_pkg::ADDR_IE, 8'h01);
    wr(gst_pkg::ADDR_IRQCTL, 8'h40);
    @(posedge sys_clk) sleep <= 1'h1;
    gst_far_side_inst.pulses(1'h0, 5, 3);
    repeat (8) @(posedge sys_clk);
    chk_bit(wake_request, 1'h1);
    @(posedge sys_clk) sleep <= 1'h0;
    wr(gst_pkg::ADDR_CTRL, 8'h06);
    expect_count(16'h0003);
    wr(gst_pkg::ADDR_FLAG, 8'h00);
    wr(gst_pkg::ADDR_IE, 8'h00);
    load_count(16'h0000);
    wr(gst_pkg::ADDR_CTRL, 8'h03);
    @(posedge sys_clk) sleep <= 1'h1;
    gst_far_side_inst.pulses(1'h0, 5, 3);
    @(posedge sys_clk) sleep <= 1'h0;
    wr(gst_pkg::ADDR_CTRL, 8'h02);
    expect_count(16'h0000);
    load_count(16'h0000);
    wr(gst_pkg::ADDR_CTRL, 8'h08);
    repeat (20) @(posedge sys_clk);
    wr(gst_pkg::ADDR_CTRL, 8'h0F);
    gst_far_side_inst.pulses(1'h1, 5, 2);
    repeat (8) @(posedge sys_clk);
    wr(gst_pkg::ADDR_CTRL, 8'h00);
    expect_count(16'h0005);
    $display("test external done");
  endtask : test_external

  task automatic test_capcomp;
    load_count(16'h0000);
    wr(gst_pkg::ADDR_CC_L, 8'h10);
    wr(gst_pkg::ADDR_CC_H, 8'h00);
    wr(gst_pkg::ADDR_CC_MODE, 8'h06);
    cmp_pulses = 0;
    run(8'h01, 100);
    expect_count(16'h000A);
    expect_reg(gst_pkg::ADDR_FLAG, 8'h00);
    chk_byte(8'(cmp_pulses), 8'h05);
    load_count(16'h0000);
    wr(gst_pkg::ADDR_CTRL, 8'h01);
    // high byte write lands on the very edge of the trigger clear
    repeat (16) @(posedge sys_clk);
    wr(gst_pkg::ADDR_CNT_H, 8'h55);
    wr(gst_pkg::ADDR_CTRL, 8'h00);
    expect_count(16'h5513);
    wr(gst_pkg::ADDR_CC_MODE, 8'h01);
    load_count(16'h0000);
    run(8'h01, 35);
    @(posedge sys_clk) capture_pin <= 1'h1;
    repeat (6) @(posedge sys_clk);
    capture_pin <= 1'h0;
    repeat (2) @(posedge sys_clk);
    expect_reg(gst_pkg::ADDR_CC_L, 8'h23);
    expect_reg(gst_pkg::ADDR_CC_H, 8'h00);
    $display("test capcomp done");
  endtask : test_capcomp

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #2_000_000;
    num_errors++;
    final_report();
  end

  initial begin
    rst_n = 1'h0;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    capture_pin = 1'h0;
    sleep = 1'h0;
    osc_bits = 4'hA;
    num_errors = 0;
    samples_checked = 0;
    cmp_pulses = 0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'h1;
    test_regs();
    test_prescale();
    test_overflow();
    test_gate();
    test_external();
    test_capcomp();
    final_report();
  end
endmodule : gst_timer_tb
